// file: verilog/acr_pkg.sv
package acr_pkg;

	// ----------------------------------------------------------------
	// Register access encodings
	// ----------------------------------------------------------------
	localparam logic [2:0] ACR_OPC1      = 3'h0;
	localparam logic [3:0] ACR_CRN       = 4'h1;
	localparam logic [3:0] ACR_CRM       = 4'h0;
	localparam logic [2:0] ACR_OPC2      = 3'h1;
	localparam logic [2:0] ACR_NSAC_OPC2 = 3'h2;
	localparam logic [3:0] ACR_NSAC_CRM  = 4'h1;

	// ----------------------------------------------------------------
	// Field positions of the auxiliary core control register
	// ----------------------------------------------------------------
	localparam int ACR_B_SNOOP_EXCL   = 31;
	localparam int ACR_B_FORCE_CLK    = 30;
	localparam int ACR_B_FORCE_SIMD   = 29;
	localparam int ACR_F_WS_L12_HI    = 28;
	localparam int ACR_F_WS_L12_LO    = 27;
	localparam int ACR_F_WS_L1_HI     = 26;
	localparam int ACR_F_WS_L1_LO     = 25;
	localparam int ACR_B_NC_STREAM    = 24;
	localparam int ACR_B_ORD_SETWAY   = 23;
	localparam int ACR_B_ORD_LOAD     = 22;
	localparam int ACR_B_DIS_TLB_PF   = 21;
	localparam int ACR_B_DIS_IPA_WC   = 20;
	localparam int ACR_B_DIS_S1_WC    = 19;
	localparam int ACR_B_DIS_S1_PA    = 18;
	localparam int ACR_B_DIS_TLB_OPT  = 17;
	localparam int ACR_B_FULL_REPLAY  = 16;
	localparam int ACR_B_ORD_BRANCH   = 15;
	localparam int ACR_B_ONE_COMMIT   = 14;
	localparam int ACR_B_FLUSH_WR     = 13;
	localparam int ACR_B_PUSH_SHADOW  = 12;
	localparam int ACR_B_ONE_PER_GRP  = 11;
	localparam int ACR_B_SERIALIZE    = 10;
	localparam int ACR_B_DIS_FLAG_REN = 9;
	localparam int ACR_B_WFI_NOP      = 8;
	localparam int ACR_B_WFE_NOP      = 7;
	localparam int ACR_B_COHERENCY    = 6;
	localparam int ACR_B_PRELOAD_NOP  = 5;
	localparam int ACR_B_DIS_IND_PRED = 4;
	localparam int ACR_B_DIS_MICRO_BT = 3;
	localparam int ACR_B_LOOP_ONCE    = 2;
	localparam int ACR_B_DIS_LOOP_BUF = 1;
	localparam int ACR_B_BTB_INV      = 0;

	// Coherency write enable inside the non-secure access control reg
	localparam int ACR_B_NS_COH_WE    = 18;

	// ----------------------------------------------------------------
	// Reset values and masks
	// ----------------------------------------------------------------
	localparam logic [31:0] ACR_RESET      = 32'h0000_0000;
	localparam logic [31:0] ACR_NSAC_RESET = 32'h0000_0000;
	localparam logic [31:0] ACR_NS_MASK    = 32'h0000_0040;
	localparam logic [31:0] ACR_NSAC_MASK  = 32'h0004_0000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef logic [1:0] acr_ws_t;

	typedef enum logic [2:0] {
		ACR_IDLE  = 3'h1,
		ACR_READ  = 3'h2,
		ACR_WRITE = 3'h4
	} acr_state_e;

endpackage

// file: verilog/acr_ctl_if.sv
`timescale 1ns/100ps
interface acr_ctl_if;
	logic [31:0] ctrl;
	logic [1:0]  ws_l12;
	logic [1:0]  ws_l1;
	logic        one_per_group;
	logic        flush_on_write;
	logic        coherency;

	modport src (output ctrl, output ws_l12, output ws_l1,
		output one_per_group, output flush_on_write, output coherency);
	modport dst (input ctrl, input ws_l12, input ws_l1,
		input one_per_group, input flush_on_write, input coherency);
endinterface

// file: verilog/acr_decode.sv
`timescale 1ns/100ps
module acr_decode
	import acr_pkg::*;
(
	// Next-state register image
	input  wire logic [31:0] ctrl_reg,
	// Decoded controls
	acr_ctl_if.src           ctl
);

	// ----------------------------------------------------------------
	// Implied bits
	// ----------------------------------------------------------------
	always_comb begin
		ctl.ctrl = ctrl_reg;
		ctl.ws_l12 = ctrl_reg[ACR_F_WS_L12_HI:ACR_F_WS_L12_LO];
		ctl.ws_l1 = ctrl_reg[ACR_F_WS_L1_HI:ACR_F_WS_L1_LO];
		// Serialization implies single-instruction groups
		ctl.one_per_group = ctrl_reg[ACR_B_ONE_PER_GRP]
			| ctrl_reg[ACR_B_SERIALIZE];
		// Shadow push implies flush after writes
		ctl.flush_on_write = ctrl_reg[ACR_B_FLUSH_WR]
			| ctrl_reg[ACR_B_PUSH_SHADOW];
		ctl.coherency = ctrl_reg[ACR_B_COHERENCY];
	end

endmodule

// file: verilog/acr_core.sv
// Overview of operation
// - Secure kernel-level code reads and writes all fields
// - Enable low: nonsecure reads work, writes ignored
// - Enable high: nonsecure writes change coherency bit only
// - One shared copy for both security states
// - Bit 31 delays snoops during exclusives
// - Bit 30 forces core clock enable
// - Bit 29 forces SIMD/FP clock enable
// - Bits 28:27 set two-level streaming threshold
// - Bits 26:25 set first-level streaming threshold
// - Bit 24 enables non-cacheable streaming enhancement
// - Bits 23,22,15 force in-order behaviour
// - Bits 21..17 disable TLB walk features
// - Bit 16 enables full ordered-load replay
// - Bit 10 serializes and implies bit 11
// - Bit 12 pushes shadows and implies bit 13
// - Bit 9 disables flag renaming; bits 4,3,2,1 predictor and loop disables
// - Bits 8,7 make wait instructions no-ops
// - Bit 6 gates maintenance broadcast reception
// - Coherency bit never touches data maintenance
// - Bit 5 makes preload hints no-ops
// - Bit 0 extends icache invalidate to BRANCH_TARGET_BUFFER
// - Coherency write enable is bit 18, resets 0
`timescale 1ns/100ps
module acr_core
	import acr_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	// Coprocessor register access
	input  wire logic        cp_valid,
	input  wire logic        cp_write,
	input  wire logic [2:0]  cp_opc1,
	input  wire logic [3:0]  cp_crn,
	input  wire logic [3:0]  cp_crm,
	input  wire logic [2:0]  cp_opc2,
	input  wire logic [31:0] cp_wdata,
	input  wire logic        cp_secure,
	input  wire logic        cp_priv,
	output logic [31:0]      cp_rdata,
	output logic             cp_ack,
	output logic             cp_undef,
	// Clock generator
	output logic             core_clk_en_force,
	output logic             simd_clk_en_force,
	// Memory system
	output logic             snoop_delay_excl,
	output logic [1:0]       ws_l12_threshold,
	output logic [1:0]       ws_l1_threshold,
	output logic             nc_stream_enh,
	output logic             order_set_way,
	output logic             order_load,
	output logic             order_branch,
	output logic             one_commit,
	output logic             full_replay,
	output logic [4:0]       tlb_disables,
	// Instruction flow
	output logic             one_per_group,
	output logic             serialize_group,
	output logic             flush_on_write,
	output logic             push_shadow,
	output logic             dis_flag_rename,
	output logic             wfi_nop,
	output logic             wfe_nop,
	output logic             preload_nop,
	output logic [3:0]       pred_disables,
	output logic             btb_invalidate,
	// Maintenance broadcast
	input  wire logic        bcast_valid,
	output logic             bcast_accept
);

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rst_s1_reg;
	logic rst_n;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rst_s1_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n <= rst_s1_reg;
		end
	end

	// ----------------------------------------------------------------
	// Access decode
	// ----------------------------------------------------------------
	logic       hit_acr;
	logic       hit_nsac;
	logic       allowed;
	acr_state_e state_reg;
	acr_state_e state_next;

	assign hit_acr = cp_opc1 == ACR_OPC1 && cp_crn == ACR_CRN
		&& cp_crm == ACR_CRM && cp_opc2 == ACR_OPC2;
	assign hit_nsac = cp_opc1 == ACR_OPC1 && cp_crn == ACR_CRN
		&& cp_crm == ACR_NSAC_CRM && cp_opc2 == ACR_NSAC_OPC2;
	assign allowed = cp_priv && (hit_acr || hit_nsac);

	always_comb begin
		state_next = ACR_IDLE;
		case (state_reg)
			ACR_IDLE: begin
				if (cp_valid && cp_write)
					state_next = ACR_WRITE;
				else if (cp_valid)
					state_next = ACR_READ;
			end
			ACR_READ:  state_next = ACR_IDLE;
			ACR_WRITE: state_next = ACR_IDLE;
			default:   state_next = ACR_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			state_reg <= ACR_IDLE;
		else
			state_reg <= state_next;
	end

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	// Single image, no banking by security state
	logic [31:0] ctrl_reg;
	logic [31:0] ctrl_next;
	logic [31:0] nsac_reg;
	logic        take;
	logic        ns_coh_we;

	assign take = state_reg == ACR_IDLE && cp_valid;
	assign ns_coh_we = nsac_reg[ACR_B_NS_COH_WE];

	always_comb begin
		ctrl_next = ctrl_reg;
		if (take && cp_write && cp_priv && hit_acr) begin
			if (cp_secure)
				ctrl_next = cp_wdata;
			else if (ns_coh_we)
				ctrl_next = (ctrl_reg & ~ACR_NS_MASK)
					| (cp_wdata & ACR_NS_MASK);
			// Otherwise nonsecure write dropped silently
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			ctrl_reg <= ACR_RESET;
		else
			ctrl_reg <= ctrl_next;
	end

	// Only secure side may change the enable
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			nsac_reg <= ACR_NSAC_RESET;
		else if (take && cp_write && cp_priv && hit_nsac && cp_secure)
			nsac_reg <= cp_wdata & ACR_NSAC_MASK;
	end

	// ----------------------------------------------------------------
	// Read and answer
	// ----------------------------------------------------------------
	// Nonsecure write to the access control reg is refused
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cp_rdata <= 32'h0000_0000;
			cp_ack <= 1'b0;
			cp_undef <= 1'b0;
		end else begin
			cp_ack <= take;
			cp_undef <= take && (!allowed
				|| (hit_nsac && cp_write && !cp_secure));
			if (take && !cp_write && cp_priv && hit_acr)
				cp_rdata <= ctrl_reg;
			else if (take && !cp_write && cp_priv && hit_nsac)
				cp_rdata <= nsac_reg;
			else
				cp_rdata <= 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// Control outputs
	// ----------------------------------------------------------------
	acr_ctl_if ctl ();

	acr_decode u_decode (
		.ctrl_reg (ctrl_next),
		.ctl      (ctl)
	);

	// Registered from next value so outputs track the store exactly
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			snoop_delay_excl <= 1'b0;
			core_clk_en_force <= 1'b0;
			simd_clk_en_force <= 1'b0;
			ws_l12_threshold <= 2'h0;
			ws_l1_threshold <= 2'h0;
			nc_stream_enh <= 1'b0;
			order_set_way <= 1'b0;
			order_load <= 1'b0;
			order_branch <= 1'b0;
			one_commit <= 1'b0;
			full_replay <= 1'b0;
			tlb_disables <= 5'h00;
		end else begin
			snoop_delay_excl <= ctl.ctrl[ACR_B_SNOOP_EXCL];
			core_clk_en_force <= ctl.ctrl[ACR_B_FORCE_CLK];
			simd_clk_en_force <= ctl.ctrl[ACR_B_FORCE_SIMD];
			ws_l12_threshold <= ctl.ws_l12;
			ws_l1_threshold <= ctl.ws_l1;
			nc_stream_enh <= ctl.ctrl[ACR_B_NC_STREAM];
			order_set_way <= ctl.ctrl[ACR_B_ORD_SETWAY];
			order_load <= ctl.ctrl[ACR_B_ORD_LOAD];
			order_branch <= ctl.ctrl[ACR_B_ORD_BRANCH];
			one_commit <= ctl.ctrl[ACR_B_ONE_COMMIT];
			full_replay <= ctl.ctrl[ACR_B_FULL_REPLAY];
			tlb_disables <= ctl.ctrl[ACR_B_DIS_TLB_PF:ACR_B_DIS_TLB_OPT];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			one_per_group <= 1'b0;
			serialize_group <= 1'b0;
			flush_on_write <= 1'b0;
			push_shadow <= 1'b0;
			dis_flag_rename <= 1'b0;
			wfi_nop <= 1'b0;
			wfe_nop <= 1'b0;
			preload_nop <= 1'b0;
			pred_disables <= 4'h0;
			btb_invalidate <= 1'b0;
		end else begin
			one_per_group <= ctl.one_per_group;
			serialize_group <= ctl.ctrl[ACR_B_SERIALIZE];
			flush_on_write <= ctl.flush_on_write;
			push_shadow <= ctl.ctrl[ACR_B_PUSH_SHADOW];
			dis_flag_rename <= ctl.ctrl[ACR_B_DIS_FLAG_REN];
			wfi_nop <= ctl.ctrl[ACR_B_WFI_NOP];
			wfe_nop <= ctl.ctrl[ACR_B_WFE_NOP];
			preload_nop <= ctl.ctrl[ACR_B_PRELOAD_NOP];
			pred_disables <= ctl.ctrl[ACR_B_DIS_IND_PRED:ACR_B_DIS_LOOP_BUF];
			btb_invalidate <= ctl.ctrl[ACR_B_BTB_INV];
		end
	end

	// ----------------------------------------------------------------
	// Maintenance broadcast gate
	// ----------------------------------------------------------------
	// Data maintenance never passes here, so it stays unaffected
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			bcast_accept <= 1'b0;
		else
			bcast_accept <= bcast_valid && ctl.coherency;
	end
	// Data path has no coherency-bit input at all

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_ns_ignored;
		@(posedge clk_sys) disable iff (!rst_n)
		(take && cp_write && hit_acr && !cp_secure && !ns_coh_we)
			|=> $stable(ctrl_reg);
	endproperty
	a_ns_ignored: assert property (p_ns_ignored)
		else $error("nonsecure write changed register");

	property p_ns_coh_only;
		@(posedge clk_sys) disable iff (!rst_n)
		(take && cp_write && cp_priv && hit_acr && !cp_secure && ns_coh_we)
			|=> ((ctrl_reg & ~ACR_NS_MASK)
				== ($past(ctrl_reg) & ~ACR_NS_MASK))
			&& ctrl_reg[ACR_B_COHERENCY] == $past(cp_wdata[ACR_B_COHERENCY]);
	endproperty
	a_ns_coh_only: assert property (p_ns_coh_only)
		else $error("nonsecure write touched other fields");

	property p_sec_write;
		@(posedge clk_sys) disable iff (!rst_n)
		(take && cp_write && cp_priv && hit_acr && cp_secure)
			|=> ctrl_reg == $past(cp_wdata) ##1 core_clk_en_force
				== ctrl_reg[ACR_B_FORCE_CLK];
	endproperty
	a_sec_write: assert property (p_sec_write)
		else $error("secure write not stored");

	property p_read_back;
		@(posedge clk_sys) disable iff (!rst_n)
		(take && !cp_write && cp_priv && hit_acr)
			|=> cp_ack && cp_rdata == $past(ctrl_reg);
	endproperty
	a_read_back: assert property (p_read_back)
		else $error("read did not return register");

	property p_group_imply;
		@(posedge clk_sys) disable iff (!rst_n)
		serialize_group |-> one_per_group;
	endproperty
	a_group_imply: assert property (p_group_imply)
		else $error("serialize without single group");

	property p_flush_imply;
		@(posedge clk_sys) disable iff (!rst_n)
		push_shadow |-> flush_on_write;
	endproperty
	a_flush_imply: assert property (p_flush_imply)
		else $error("push without flush");

	property p_bcast;
		@(posedge clk_sys) disable iff (!rst_n)
		(bcast_valid && !ctl.coherency) |=> !bcast_accept;
	endproperty
	a_bcast: assert property (p_bcast)
		else $error("broadcast accepted while not coherent");

	property p_nsac_ns_write;
		@(posedge clk_sys) disable iff (!rst_n)
		(take && cp_write && hit_nsac && !cp_secure)
			|=> cp_undef && $stable(nsac_reg);
	endproperty
	a_nsac_ns_write: assert property (p_nsac_ns_write)
		else $error("nonsecure write reached access control");

	property p_unpriv;
		@(posedge clk_sys) disable iff (!rst_n)
		(take && !cp_priv)
			|=> cp_undef && cp_rdata == 32'h0000_0000
				&& $stable(ctrl_reg);
	endproperty
	a_unpriv: assert property (p_unpriv)
		else $error("unprivileged access not refused");

	property p_wfi;
		@(posedge clk_sys) disable iff (!rst_n)
		##1 (wfi_nop == $past(ctrl_next[ACR_B_WFI_NOP]))
			&& (btb_invalidate == $past(ctrl_next[ACR_B_BTB_INV]));
	endproperty
	a_wfi: assert property (p_wfi)
		else $error("wait no-op or invalidate output wrong");

endmodule

// file: sim/tb_aux_control_register.sv
`timescale 1ns/100ps
module tb_aux_control_register;
	import acr_pkg::*;

	// ----------------------------------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------------------------------
	logic        clk_sys, resetn, cp_valid, cp_write, cp_secure, cp_priv;
	logic        bcast_valid;
	logic [2:0]  cp_opc1, cp_opc2;
	logic [3:0]  cp_crn, cp_crm;
	logic [31:0] cp_wdata;
	wire  [31:0] cp_rdata;
	wire         cp_ack, cp_undef, bcast_accept;
	wire         c_clk, c_simd, c_snp, c_nc, c_osw, c_old, c_obr, c_one;
	wire         c_rep, c_opg, c_ser, c_flw, c_psh, c_dfr, c_wfi, c_wfe;
	wire         c_pre, c_btb;
	wire  [1:0]  c_ws12, c_ws1;
	wire  [4:0]  c_tlb;
	wire  [3:0]  c_pred;
	wire  [30:0] ctl_seen;
	int          miscompares = 0;
	int          num_checks  = 0;
	logic [31:0] model;
	logic        ns_en;
	logic [31:0] rd;
	logic        und;

	assign ctl_seen = {c_snp, c_clk, c_simd, c_ws12, c_ws1, c_nc, c_osw,
		c_old, c_obr, c_one, c_rep, c_tlb, c_opg, c_ser, c_flw, c_psh,
		c_dfr, c_wfi, c_wfe, c_pre, c_pred, c_btb};

	acr_core i_dut (.clk_sys(clk_sys), .resetn(resetn),
		.cp_valid(cp_valid), .cp_write(cp_write), .cp_opc1(cp_opc1),
		.cp_crn(cp_crn), .cp_crm(cp_crm), .cp_opc2(cp_opc2),
		.cp_wdata(cp_wdata), .cp_secure(cp_secure), .cp_priv(cp_priv),
		.cp_rdata(cp_rdata), .cp_ack(cp_ack), .cp_undef(cp_undef),
		.core_clk_en_force(c_clk), .simd_clk_en_force(c_simd),
		.snoop_delay_excl(c_snp), .ws_l12_threshold(c_ws12),
		.ws_l1_threshold(c_ws1), .nc_stream_enh(c_nc),
		.order_set_way(c_osw), .order_load(c_old), .order_branch(c_obr),
		.one_commit(c_one), .full_replay(c_rep), .tlb_disables(c_tlb),
		.one_per_group(c_opg), .serialize_group(c_ser),
		.flush_on_write(c_flw), .push_shadow(c_psh),
		.dis_flag_rename(c_dfr), .wfi_nop(c_wfi), .wfe_nop(c_wfe),
		.preload_nop(c_pre), .pred_disables(c_pred),
		.btb_invalidate(c_btb), .bcast_valid(bcast_valid),
		.bcast_accept(bcast_accept));

	// ----------------------------------------------------------------
	// Expectation functions
	// ----------------------------------------------------------------
	function automatic logic [30:0] exp_ctl(input logic [31:0] v);
		return {v[31], v[30], v[29], v[28:27], v[26:25], v[24], v[23],
			v[22], v[15], v[14], v[16], v[21:17], v[11] | v[10], v[10],
			v[13] | v[12], v[12], v[9], v[8], v[7], v[5], v[4:1], v[0]};
	endfunction

	// Nonsecure side may only move the coherency bit, and only if enabled
	function automatic logic [31:0] nxt(input logic [31:0] cur,
		input logic [31:0] wd, input logic s, input logic en);
		if (s)
			return wd;
		if (en)
			return (cur & ~ACR_NS_MASK) | (wd & ACR_NS_MASK);
		return cur;
	endfunction

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic give_verdict();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] e,
		input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", what, e, g);
			miscompares++;
		end
	endtask

	// Request held until the answer is seen; the block ignores it in
	// the busy cycle after taking, so it is never taken twice
	task automatic acc(input logic w, input logic s, input logic p,
		input logic nsr, input logic bad, input logic [31:0] wd);
		int n;
		logic ack_seen;
		n = 0;
		@(posedge clk_sys);
		cp_valid  <= 1'b1;
		cp_write  <= w;
		cp_secure <= s;
		cp_priv   <= p;
		cp_opc1   <= ACR_OPC1;
		cp_crn    <= bad ? 4'h2 : ACR_CRN;
		cp_crm    <= nsr ? ACR_NSAC_CRM : ACR_CRM;
		cp_opc2   <= nsr ? ACR_NSAC_OPC2 : ACR_OPC2;
		cp_wdata  <= wd;
		do begin
			@(negedge clk_sys);
			n++;
		end while (cp_ack !== 1'b1 && n < 4);
		ack_seen = cp_ack;
		rd  = cp_rdata;
		und = cp_undef;
		@(posedge clk_sys);
		cp_valid  <= 1'b0;
		if (ack_seen !== 1'b1) begin
			$display("BAD cp_ack expected 1 seen %b", ack_seen);
			miscompares++;
			give_verdict();
		end
	endtask

	task automatic bc();
		logic r;
		r = 1'($urandom);
		@(posedge clk_sys);
		bcast_valid <= r;
		@(posedge clk_sys);
		#1;
		chk("bcast_accept", {31'h0, r & model[ACR_B_COHERENCY]},
			{31'h0, bcast_accept});
	endtask

	// Write through the aux register, then check every effect
	task automatic wr(input logic s, input logic p, input logic [31:0] wd);
		if (p)
			model = nxt(model, wd, s, ns_en);
		acc(1'b1, s, p, 1'b0, 1'b0, wd);
		chk("undef", {31'h0, ~p}, {31'h0, und});
		chk("controls", {1'b0, exp_ctl(model)}, {1'b0, ctl_seen});
		acc(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 32'h0);
		chk("secure read", model, rd);
		acc(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 32'h0);
		chk("nonsecure read", model, rd);
		bc();
	endtask

	// Random filler stays off the enable bit, which only e may set
	task automatic set_en(input logic e);
		logic [31:0] wd;
		wd = ($urandom & ~ACR_NSAC_MASK) | 32'(e) << ACR_B_NS_COH_WE;
		ns_en = e;
		acc(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, wd);
		acc(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 32'h0);
		chk("access ctrl read", 32'(e) << ACR_B_NS_COH_WE, rd);
	endtask

	// ----------------------------------------------------------------
	// Clock, reset and main sequence
	// ----------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	initial begin
		repeat (20000) @(posedge clk_sys);
		$display("BAD run time expected done seen hung");
		miscompares++;
		give_verdict();
	end

	initial begin
		resetn = 1'b0; cp_valid = 1'b0; cp_write = 1'b0; cp_secure = 1'b0;
		cp_priv = 1'b0; bcast_valid = 1'b0; cp_opc1 = 3'h0; cp_opc2 = 3'h0;
		cp_crn = 4'h0; cp_crm = 4'h0; cp_wdata = 32'h0;
		model = ACR_RESET;
		ns_en = 1'b0;
		void'($urandom(32'hE1EA5953));
		repeat (6) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		#1;
		chk("reset controls", 32'h0, {1'b0, ctl_seen});
		acc(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 32'h0);
		chk("access ctrl reset", ACR_NSAC_RESET, rd);
		wr(1'b1, 1'b1, 32'h0000_0040);
		wr(1'b0, 1'b1, 32'hFFFF_FFFF);
		for (int i = 0; i < 32; i++) begin
			wr(1'b1, 1'b1, 32'h1 << i);
		end
		wr(1'b1, 1'b1, 32'h0000_0400);
		wr(1'b1, 1'b1, 32'h0000_1000);
		for (int k = 0; k < 4; k++) begin
			wr(1'b1, 1'b1, {$urandom} & 32'hF9FF_FFFF | 32'(k) << 25);
			wr(1'b1, 1'b1, {$urandom} & 32'hE7FF_FFFF | 32'(k) << 27);
		end
		wr(1'b0, 1'b1, ~model);
		set_en(1'b1);
		for (int k = 0; k < 6; k++) begin
			wr(1'b0, 1'b1, $urandom);
			wr(1'b0, 1'b1, ~model);
		end
		acc(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 32'h0);
		chk("nonsecure access ctrl write", 32'h1, {31'h0, und});
		set_en(1'b0);
		wr(1'b0, 1'b1, ~model);
		wr(1'b1, 1'b0, ~model);
		acc(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 32'h0);
		chk("unmapped undef", 32'h1, {31'h0, und});
		chk("unmapped rdata", 32'h0, rd);
		// Unprivileged read is refused and returns nothing
		acc(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 32'h0);
		chk("unprivileged undef", 32'h1, {31'h0, und});
		chk("unprivileged rdata", 32'h0, rd);
		for (int k = 0; k < 8; k++) begin
			wr(1'($urandom), 1'b1, $urandom);
		end
		// Reset again mid-run
		@(posedge clk_sys);
		resetn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		resetn <= 1'b1;
		model = ACR_RESET;
		ns_en = 1'b0;
		repeat (3) @(posedge clk_sys);
		#1;
		chk("second reset", 32'h0, {1'b0, ctl_seen});
		set_en(1'b0);
		wr(1'b1, 1'b1, 32'h0000_0040);
		give_verdict();
	end
endmodule
